// File: verilog/link_err_defines.svh
// register offsets, field positions and reset values for link error routing
`ifndef LINK_ERR_DEFINES_SVH
`define LINK_ERR_DEFINES_SVH
`define REG_FIRST_ERR 8'h50
`define REG_NEXT_ERR 8'h52
`define REG_ERR_MASK 8'h54
`define REG_CTL_EN 8'h58
`define REG_MGMT_EN 8'h5A
`define REG_MSG_STAT 8'h5C
`define FLAG_BITS 7
`define FLAG_MSB 6
`define EN_RESERVED_BIT 7
`define EN_RESET 8'h00
`define LOG_RESET 8'h00
`define MASK_RESET 8'h00
`define MSG_CTL 1'b0
`define MSG_MGMT 1'b1
`endif

// File: verilog/link_err_pkg.sv
// types shared by the link error routing block
package link_err_pkg;
  typedef enum logic [1:0] {IDLE, READ_DONE, WRITE_DONE} bus_state_t;
  typedef logic [6:0] flags_t;
endpackage

// File: verilog/link_msg_if.sv
// event message request and handshake between router and link sender
`timescale 1ns/1ps
interface link_msg_if;
  logic req;
  logic kind;
  logic [6:0] flag;
  logic ack;
  modport router (output req, output kind, output flag, input ack);
  modport sender (input req, input kind, input flag, output ack);
endinterface

// File: verilog/link_msg_sender.sv
// drives one event special cycle per request onto the link outputs
`timescale 1ns/1ps
`include "link_err_defines.svh"
module link_msg_sender
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  link_msg_if.sender msg,
  output logic cyc_valid_o,
  output logic cyc_kind_o,
  output logic [6:0] cyc_flag_o
);
  typedef struct packed
  {
    logic valid;
    logic kind;
    logic [6:0] flag;
  } snd_state_t;
  snd_state_t st;
  snd_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.valid = 1'b0;
    if (msg.req && !st.valid)
    begin
      next_st.valid = 1'b1;
      next_st.kind = msg.kind;
      next_st.flag = msg.flag;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  // ack in the cycle the message is launched
  assign msg.ack = st.valid;
  assign cyc_valid_o = st.valid;
  assign cyc_kind_o = st.kind;
  assign cyc_flag_o = st.flag;

  one_cycle_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cyc_valid_o |=> !cyc_valid_o)
    else $error("special cycle held longer than one clock");
endmodule

// File: verilog/link_err_router.sv
// hub link error logs and routing of errors into event special cycles
// Functional notes
// - enabled logged flag sends a system-control event special cycle
// - enabled logged flag sends a management-mode event special cycle
// - both enable registers are 8-bit, bits 0..6 read/write, reset to zero
// - control enable bit 6 gates target-abort event
// - control enable bit 5 gates misdirected enhanced config access event
// - control enable bit 4 gates link data parity error event
// - control enable bit 3 gates out-of-range address event
// - control enable bit 2 gates bridge internal parity error event
// - control enable bit 1 gates illegal access event
// - control enable bit 0 gates address/command parity error event
// - management enable bits 0..6 gate the same flags likewise
// - enable bit 7 reserved, reads zero, no effect
// - first error goes to first log, later ones to next log
// - masked errors are not logged and send nothing
// - logs survive reset; write one clears, zero keeps
`timescale 1ns/1ps
`include "link_err_defines.svh"
module link_err_router
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_readdatavalid,
  input wire logic [6:0] err_detect_i,
  output logic cyc_valid_o,
  output logic cyc_kind_o,
  output logic [6:0] cyc_flag_o
);
  typedef struct packed
  {
    link_err_pkg::bus_state_t bus;
    logic [31:0] rdata;
    logic [7:0] ctl_en;
    logic [7:0] mgmt_en;
    link_err_pkg::flags_t pend_ctl;
    link_err_pkg::flags_t pend_mgmt;
    link_err_pkg::flags_t seen;
    logic [2:0] msg_count;
  } rt_state_t;

  // logs and mask live outside the reset so they survive it
  typedef struct packed
  {
    link_err_pkg::flags_t first_log;
    link_err_pkg::flags_t next_log;
    link_err_pkg::flags_t mask;
  } sticky_t;

  rt_state_t st;
  rt_state_t next_st;
  sticky_t sk = '0;
  sticky_t next_sk;
  link_msg_if msg ();

  function automatic logic [2:0] lowest(input link_err_pkg::flags_t v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = `FLAG_MSB; i >= 0; i--)
      if (v[i])
        idx = 3'(i);
    return idx;
  endfunction

  logic wr_hit;
  logic rd_hit;
  link_err_pkg::flags_t new_err;
  link_err_pkg::flags_t logged;
  link_err_pkg::flags_t rise;
  link_err_pkg::flags_t wclr;

  always_comb
  begin
    wr_hit = avs_write && st.bus == link_err_pkg::IDLE;
    rd_hit = avs_read && st.bus == link_err_pkg::IDLE;
    wclr = avs_writedata[6:0];
    new_err = err_detect_i & ~sk.mask;
    logged = sk.first_log | sk.next_log;
    rise = logged & ~st.seen;
  end

  always_comb
  begin
    next_sk = sk;
    if (wr_hit && avs_address == `REG_FIRST_ERR)
      next_sk.first_log = sk.first_log & ~wclr;
    if (wr_hit && avs_address == `REG_NEXT_ERR)
      next_sk.next_log = sk.next_log & ~wclr;
    if (wr_hit && avs_address == `REG_ERR_MASK)
      next_sk.mask = wclr;
    // set wins over a same-cycle clear
    if (new_err != 7'h00)
    begin
      if (next_sk.first_log == 7'h00 && sk.first_log == 7'h00)
      begin
        next_sk.first_log = new_err & (~new_err + 7'h01);
        // other bits of a multi-bit error count as later errors
        next_sk.next_log = next_sk.next_log | (new_err & ~next_sk.first_log);
      end
      else
        next_sk.next_log = next_sk.next_log | new_err;
    end
  end

  always_ff @(posedge ref_clk_i)
    sk <= next_sk;

  always_comb
  begin
    next_st = st;
    next_st.seen = logged;
    // a flag newly set queues one message per enabled type
    next_st.pend_ctl = st.pend_ctl | (rise & st.ctl_en[6:0]);
    next_st.pend_mgmt = st.pend_mgmt | (rise & st.mgmt_en[6:0]);
    // clear from the launched copy: the request may already name another flag
    if (msg.ack)
    begin
      if (cyc_kind_o == `MSG_CTL)
        next_st.pend_ctl = next_st.pend_ctl & ~cyc_flag_o;
      else
        next_st.pend_mgmt = next_st.pend_mgmt & ~cyc_flag_o;
      next_st.msg_count = st.msg_count + 3'h1;
    end
    case (st.bus)
      link_err_pkg::IDLE:
      begin
        if (rd_hit)
        begin
          next_st.bus = link_err_pkg::READ_DONE;
          case (avs_address)
            `REG_FIRST_ERR: next_st.rdata = {25'h0, sk.first_log};
            `REG_NEXT_ERR: next_st.rdata = {25'h0, sk.next_log};
            `REG_ERR_MASK: next_st.rdata = {25'h0, sk.mask};
            `REG_CTL_EN: next_st.rdata = {24'h0, st.ctl_en};
            `REG_MGMT_EN: next_st.rdata = {24'h0, st.mgmt_en};
            `REG_MSG_STAT: next_st.rdata = {17'h0, st.pend_mgmt,
                                            st.pend_ctl[6:0], 1'b0};
            default: next_st.rdata = 32'h0;
          endcase
        end
        else if (wr_hit)
        begin
          next_st.bus = link_err_pkg::WRITE_DONE;
          if (avs_address == `REG_CTL_EN)
            next_st.ctl_en = {1'b0, avs_writedata[6:0]};
          if (avs_address == `REG_MGMT_EN)
            next_st.mgmt_en = {1'b0, avs_writedata[6:0]};
        end
      end
      link_err_pkg::READ_DONE: next_st.bus = link_err_pkg::IDLE;
      link_err_pkg::WRITE_DONE: next_st.bus = link_err_pkg::IDLE;
      default: next_st.bus = link_err_pkg::IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.ctl_en <= `EN_RESET;
      st.mgmt_en <= `EN_RESET;
      st.seen <= 7'h7F;
    end
    else
      st <= next_st;
  end

  // control events first; keeps both types from competing per flag
  always_comb
  begin
    msg.req = (st.pend_ctl | st.pend_mgmt) != 7'h00;
    msg.kind = (st.pend_ctl != 7'h00) ? `MSG_CTL : `MSG_MGMT;
    msg.flag = '0;
    if (st.pend_ctl != 7'h00)
      msg.flag[lowest(st.pend_ctl)] = 1'b1;
    else
      msg.flag[lowest(st.pend_mgmt)] = 1'b1;
  end

  link_msg_sender u_sender
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .msg(msg.sender),
    .cyc_valid_o(cyc_valid_o),
    .cyc_kind_o(cyc_kind_o),
    .cyc_flag_o(cyc_flag_o)
  );

  // waitrequest low exactly in the answer cycle
  assign avs_waitrequest = !(st.bus != link_err_pkg::IDLE);
  assign avs_readdata = st.rdata;
  assign avs_readdatavalid = st.bus == link_err_pkg::READ_DONE;

  sequence en_write_s;
    wr_hit && avs_address == `REG_CTL_EN;
  endsequence

  ctl_en_store_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_write_s |=> st.ctl_en == {1'b0, $past(avs_writedata[6:0])})
    else $error("control enable not stored");
  rsvd_zero_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !st.ctl_en[7] && !st.mgmt_en[7])
    else $error("reserved enable bit set");
  ctl_gate_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cyc_valid_o && cyc_kind_o == `MSG_CTL |->
    (cyc_flag_o & $past(st.ctl_en[6:0], 2)) != 7'h00)
    else $error("control event for disabled flag");
  mgmt_gate_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cyc_valid_o && cyc_kind_o == `MSG_MGMT |->
    (cyc_flag_o & $past(st.mgmt_en[6:0], 2)) != 7'h00)
    else $error("management event for disabled flag");
  ctl_send_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rise & st.ctl_en[6:0]) != 7'h00 |-> ##[1:16] cyc_valid_o)
    else $error("control event not sent");
  mgmt_send_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rise & st.mgmt_en[6:0]) != 7'h00 |-> ##[1:16] cyc_valid_o)
    else $error("management event not sent");
  masked_a: assert property (
    @(posedge ref_clk_i)
    (err_detect_i & sk.mask) != 7'h00 && (err_detect_i & ~sk.mask) == 7'h00
    && !wr_hit |=> sk.first_log == $past(sk.first_log))
    else $error("masked error logged");
  wait_low_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer later than one cycle");
endmodule

// File: dv/link_hub_model.sv
// far-side hub model that receives event special cycles
`timescale 1ns/1ps
module link_hub_model
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic valid_i,
  input wire logic kind_i,
  input wire logic [6:0] flag_i,
  output logic [7:0] count_o,
  output logic last_kind_o,
  output logic [6:0] last_flag_o
);
  // every pulse counts, so a repeated message shows as a count above one
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      count_o <= 8'h00;
    else if (valid_i)
      count_o <= count_o + 8'h01;
    if (valid_i)
      last_kind_o <= kind_i;
    if (valid_i)
      last_flag_o <= flag_i;
  end
endmodule

// File: dv/test_link_error_event_routing.sv
// self-checking bench for the link error event router
`timescale 1ns/1ps
`include "link_err_defines.svh"
module test_link_error_event_routing;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic avs_readdatavalid;
  logic [6:0] err_detect_i = 7'h00;
  logic cyc_valid_o;
  logic cyc_kind_o;
  logic [6:0] cyc_flag_o;
  logic [7:0] cnt;
  logic last_kind;
  logic [6:0] last_flag;
  int fails = 0;
  int checks = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  link_err_router link_err_router_i (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_readdatavalid(avs_readdatavalid), .err_detect_i(err_detect_i),
    .cyc_valid_o(cyc_valid_o), .cyc_kind_o(cyc_kind_o),
    .cyc_flag_o(cyc_flag_o));
  link_hub_model link_hub_model_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .valid_i(cyc_valid_o), .kind_i(cyc_kind_o), .flag_i(cyc_flag_o),
    .count_o(cnt), .last_kind_o(last_kind), .last_flag_o(last_flag));
  task report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one transfer; request held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do
      @(posedge ref_clk_i);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    if (!w)
      check("read data valid", avs_readdatavalid, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task reset_values;
    logic [31:0] q;
    bus(1'b0, `REG_CTL_EN, 32'h0, q);
    check("ctl enable reset", q, 32'h0);
    bus(1'b0, `REG_MGMT_EN, 32'h0, q);
    check("mgmt enable reset", q, 32'h0);
    bus(1'b1, `REG_CTL_EN, 32'hFF, q);
    bus(1'b0, `REG_CTL_EN, 32'h0, q);
    check("ctl enable rw", q, 32'h7F);
    bus(1'b1, `REG_MGMT_EN, 32'hFF, q);
    bus(1'b0, `REG_MGMT_EN, 32'h0, q);
    check("mgmt enable rw", q, 32'h7F);
  endtask
  // enabled bit held 4 cycles, then a disabled neighbour; logs then cleared
  task route_bit(input logic kind, input int b);
    logic [31:0] q;
    logic [7:0] c;
    logic [6:0] m;
    logic [6:0] o;
    m = 7'h01 << b;
    o = 7'h01 << ((b + 1) % 7);
    bus(1'b1, kind ? `REG_MGMT_EN : `REG_CTL_EN, {25'h0, m}, q);
    bus(1'b1, kind ? `REG_CTL_EN : `REG_MGMT_EN, 32'h0, q);
    c = cnt;
    err_detect_i <= m;
    repeat (4) @(posedge ref_clk_i);
    err_detect_i <= o;
    @(posedge ref_clk_i);
    err_detect_i <= 7'h00;
    repeat (8) @(posedge ref_clk_i);
    check("message count", 8'(cnt - c), 32'h1);
    check("message kind", last_kind, kind);
    check("message flag", last_flag, m);
    bus(1'b0, `REG_FIRST_ERR, 32'h0, q);
    check("first log", q, {25'h0, m});
    bus(1'b0, `REG_NEXT_ERR, 32'h0, q);
    // the held enabled bit is seen again after the first log is full
    check("next log", q, {25'h0, m | o});
    bus(1'b1, `REG_FIRST_ERR, 32'h7F, q);
    bus(1'b1, `REG_NEXT_ERR, 32'h7F, q);
    bus(1'b0, `REG_FIRST_ERR, 32'h0, q);
    check("log cleared", q, 32'h0);
  endtask
  task mask_and_sticky;
    logic [31:0] q;
    logic [7:0] c;
    bus(1'b1, `REG_ERR_MASK, 32'h08, q);
    bus(1'b1, `REG_CTL_EN, 32'h08, q);
    c = cnt;
    err_detect_i <= 7'h08;
    @(posedge ref_clk_i);
    err_detect_i <= 7'h04;
    @(posedge ref_clk_i);
    err_detect_i <= 7'h00;
    repeat (8) @(posedge ref_clk_i);
    check("masked count", 8'(cnt - c), 32'h0);
    bus(1'b0, `REG_FIRST_ERR, 32'h0, q);
    check("masked log", q, 32'h04);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    bus(1'b0, `REG_FIRST_ERR, 32'h0, q);
    check("log after reset", q, 32'h04);
    bus(1'b0, `REG_CTL_EN, 32'h0, q);
    check("enable after reset", q, 32'h0);
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    report_and_stop();
  end
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    reset_values();
    for (int k = 0; k < 2; k++)
      for (int b = 0; b < 7; b++)
        route_bit(k[0], b);
    mask_and_sticky();
    report_and_stop();
  end
endmodule
